// File: ssp_core.sv
// Serial peripheral port: status, data buffer, clock rate and shifter.
// Assumes an Avalon-MM master on the register side and port-one pins whose
// levels are already synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module ssp_core (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [ssp_pkg::BUS_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [ssp_pkg::BUS_DW-1:0] avs_writedata,
    output logic [ssp_pkg::BUS_DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Timer and interrupt request
    input wire logic timer1_ovf,
    output logic port_irq,
    // Port one pins
    input wire logic [7:0] p1_in,
    output logic [7:0] p1_out,
    output logic [7:0] p1_oe
);
    import ssp_pkg::*;

    typedef struct packed {
        logic bus_ack;
        logic [7:0] rdata;
        logic [7:0] ctrl;
        logic [7:0] stat;
        logic stat_rd;
        ssp_state_e state;
        logic [7:0] sh;
        logic [7:0] rx_last;
        logic [3:0] cnt;
        logic half;
        logic in_bit;
        logic [6:0] div;
        logic sck;
        logic sck_prev;
        logic [7:0] pout;
        logic [7:0] poe;
    } ssp_core_s;

    ssp_core_s st;
    ssp_core_s next_st;

    // ********************************************************************
    // Helper functions
    // ********************************************************************
    function automatic logic [6:0] half_limit(input logic [2:0] code);
        half_limit = 7'((1 << code) - 1);
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b, input logic lsb);
        shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction

    function automatic logic [2:0] pin_of(input logic remap, input logic [2:0] def, input logic [2:0] alt);
        pin_of = remap ? alt : def;
    endfunction

    logic bus_req;
    logic acc;
    logic sel_ctrl;
    logic sel_stat;
    logic sel_data;
    logic master;
    logic port_on;
    logic lsb_first;
    logic [2:0] rate;
    logic [2:0] pin_ss;
    logic [2:0] pin_mosi;
    logic [2:0] pin_miso;
    logic [2:0] pin_sck;
    logic ss_n;
    logic selected;
    logic clash_now;
    logic tick;
    logic out_bit;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [7:0] fifo_out_data;

    assign bus_req = avs_read || avs_write;
    assign acc = bus_req && st.bus_ack;
    assign sel_ctrl = avs_address[BUS_AW-1:2] == IDX_CTRL;
    assign sel_stat = avs_address[BUS_AW-1:2] == IDX_STAT;
    assign sel_data = avs_address[BUS_AW-1:2] == IDX_DATA;
    assign avs_waitrequest = bus_req && !st.bus_ack;
    assign avs_readdata = {24'h000000, st.rdata};
    assign master = st.ctrl[CTL_MASTER];
    assign port_on = st.ctrl[CTL_PORT_ON];
    assign lsb_first = st.stat[ST_BIT_ORDER];
    assign rate = st.ctrl[CTL_RATE_LO +: 3];
    assign pin_ss = pin_of(st.stat[ST_REMAP], PIN_SS_DEF, PIN_SS_ALT);
    assign pin_mosi = pin_of(st.stat[ST_REMAP], PIN_MOSI_DEF, PIN_MOSI_ALT);
    assign pin_miso = pin_of(st.stat[ST_REMAP], PIN_MISO_DEF, PIN_MISO_ALT);
    assign pin_sck = pin_of(st.stat[ST_REMAP], PIN_SCK_DEF, PIN_SCK_ALT);
    assign ss_n = p1_in[pin_ss];
    assign selected = st.ctrl[CTL_SEL_IGNORE] || !ss_n;
    assign clash_now = port_on && master && !st.ctrl[CTL_SEL_IGNORE] && !ss_n;
    assign tick = (rate == RATE_TIMER) ? timer1_ovf : (st.div == half_limit(rate));
    assign out_bit = lsb_first ? st.sh[0] : st.sh[7];
    assign fifo_in_valid = acc && avs_write && sel_data;
    assign fifo_out_ready = st.state == SSP_IDLE && port_on && !clash_now && (master || selected);
    assign p1_out = st.pout;
    assign p1_oe = st.poe;
    assign port_irq = st.ctrl[CTL_IRQ_EN] && (st.stat[ST_XFER_DONE] || st.stat[ST_MASTER_CLASH]
        || (st.stat[ST_TX_EMPTY] && st.stat[ST_TX_IRQ_EN]));

    // ********************************************************************
    // Transmit buffer
    // ********************************************************************
    ssp_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(avs_writedata[7:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // ********************************************************************
    // Next state
    // ********************************************************************
    always_comb begin
        next_st = st;
        next_st.bus_ack = bus_req && !st.bus_ack;
        if (bus_req && !st.bus_ack) begin
            if (sel_ctrl) begin
                next_st.rdata = st.ctrl;
            end else if (sel_stat) begin
                next_st.rdata = st.stat;
            end else if (sel_data) begin
                next_st.rdata = st.rx_last;
            end else begin
                next_st.rdata = 8'h00;
            end
        end
        // Software writes and clears come first so that hardware sets win.
        if (acc && avs_write && sel_ctrl) begin
            next_st.ctrl = avs_writedata[7:0];
        end
        if (acc && avs_write && sel_stat) begin
            next_st.stat[7:3] = st.stat[7:3] & avs_writedata[7:3];
            next_st.stat[2:0] = avs_writedata[2:0];
        end
        if (acc && sel_data) begin
            next_st.stat_rd = 1'b0;
            if (st.stat_rd) begin
                next_st.stat[ST_XFER_DONE] = 1'b0;
                next_st.stat[ST_WRITE_CLASH] = 1'b0;
            end
        end else if (acc && avs_read && sel_stat) begin
            next_st.stat_rd = 1'b1;
        end
        if (fifo_in_valid && !fifo_in_ready) begin
            next_st.stat[ST_WRITE_CLASH] = 1'b1;
        end
        if (clash_now) begin
            next_st.stat[ST_MASTER_CLASH] = 1'b1;
        end
        next_st.sck_prev = p1_in[pin_sck];
        next_st.div = (tick || st.state != SSP_SHIFT) ? 7'h00 : st.div + 7'h01;
        case (st.state)
            SSP_IDLE: begin
                next_st.cnt = 4'h0;
                next_st.half = 1'b0;
                next_st.sck = 1'b0;
                if (fifo_out_ready && fifo_out_valid) begin
                    next_st.sh = fifo_out_data;
                    next_st.stat[ST_TX_EMPTY] = 1'b1;
                    next_st.state = SSP_SHIFT;
                end else if (fifo_out_ready && !master) begin
                    next_st.sh = st.rx_last;
                    next_st.state = SSP_SHIFT;
                end
            end
            SSP_SHIFT: begin
                if (!port_on || (master && clash_now) || master != st.ctrl[CTL_MASTER]) begin
                    next_st.state = SSP_IDLE;
                end else if (master) begin
                    if (tick && !st.sck) begin
                        next_st.sck = 1'b1;
                        next_st.in_bit = p1_in[pin_miso];
                    end else if (tick) begin
                        next_st.sck = 1'b0;
                        next_st.sh = shift_in(st.sh, st.in_bit, lsb_first);
                        next_st.cnt = st.cnt + 4'h1;
                        if (st.cnt == BITS_LAST) begin
                            next_st.state = SSP_DONE;
                        end
                    end
                end else if (!selected) begin
                    if (st.cnt != 4'h0 || st.half) begin
                        next_st.stat[ST_DROPOUT] = 1'b1;
                    end
                    next_st.state = SSP_IDLE;
                end else if (p1_in[pin_sck] && !st.sck_prev) begin
                    next_st.in_bit = p1_in[pin_mosi];
                    next_st.half = 1'b1;
                end else if (!p1_in[pin_sck] && st.sck_prev && st.half) begin
                    next_st.half = 1'b0;
                    next_st.sh = shift_in(st.sh, st.in_bit, lsb_first);
                    next_st.cnt = st.cnt + 4'h1;
                    if (st.cnt == BITS_LAST) begin
                        next_st.state = SSP_DONE;
                    end
                end
            end
            SSP_DONE: begin
                next_st.stat[ST_XFER_DONE] = 1'b1;
                next_st.rx_last = st.sh;
                next_st.state = SSP_IDLE;
            end
            default: begin
                next_st.state = SSP_IDLE;
            end
        endcase
        next_st.pout = 8'h00;
        next_st.poe = 8'h00;
        if (port_on && master) begin
            next_st.pout[pin_sck] = next_st.sck;
            next_st.poe[pin_sck] = 1'b1;
            next_st.pout[pin_mosi] = lsb_first ? next_st.sh[0] : next_st.sh[7];
            next_st.poe[pin_mosi] = 1'b1;
        end else if (port_on && selected) begin
            next_st.pout[pin_miso] = lsb_first ? next_st.sh[0] : next_st.sh[7];
            next_st.poe[pin_miso] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ********************************************************************
    // Assertions
    // ********************************************************************
    sequence s_req_first;
        bus_req && !st.bus_ack;
    endsequence

    sequence s_answer;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence

    property p_bus_answer;
        @(posedge clk) disable iff (sys_rst) s_req_first |-> s_answer;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer not after one wait");

    property p_read_data;
        @(posedge clk) disable iff (sys_rst)
            (s_req_first and (avs_read && sel_data)) |=> avs_readdata[7:0] == $past(st.rx_last);
    endproperty
    a_read_data: assert property (p_read_data) else $error("data read not last received");

    property p_done_flag;
        @(posedge clk) disable iff (sys_rst) st.state == SSP_DONE |=> st.stat[ST_XFER_DONE] && port_irq == st.ctrl[CTL_IRQ_EN];
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done flag or interrupt missing");

    property p_auto_clear;
        @(posedge clk) disable iff (sys_rst)
            acc && sel_data && st.stat_rd && st.state != SSP_DONE |=> !st.stat[ST_XFER_DONE];
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("done flag not cleared by sequence");

    property p_no_arm;
        @(posedge clk) disable iff (sys_rst)
            acc && sel_data && !st.stat_rd && st.stat[ST_XFER_DONE] |=> st.stat[ST_XFER_DONE];
    endproperty
    a_no_arm: assert property (p_no_arm) else $error("done flag cleared without status read");

    property p_write_clash;
        @(posedge clk) disable iff (sys_rst) fifo_in_valid && !fifo_in_ready |=> st.stat[ST_WRITE_CLASH];
    endproperty
    a_write_clash: assert property (p_write_clash) else $error("write clash not flagged");

    property p_clash_set;
        @(posedge clk) disable iff (sys_rst) clash_now |=> st.stat[ST_MASTER_CLASH] && st.state != SSP_SHIFT;
    endproperty
    a_clash_set: assert property (p_clash_set) else $error("master collision not flagged");

    property p_clash_hold;
        @(posedge clk) disable iff (sys_rst)
            st.stat[ST_MASTER_CLASH] && !(acc && avs_write && sel_stat) |=> st.stat[ST_MASTER_CLASH];
    endproperty
    a_clash_hold: assert property (p_clash_hold) else $error("master collision flag lost");

    property p_tx_empty;
        @(posedge clk) disable iff (sys_rst) fifo_out_ready && fifo_out_valid |=> st.stat[ST_TX_EMPTY];
    endproperty
    a_tx_empty: assert property (p_tx_empty) else $error("empty flag not set on load");

    property p_tx_irq;
        @(posedge clk) disable iff (sys_rst)
            !st.stat[ST_XFER_DONE] && !st.stat[ST_MASTER_CLASH] |-> port_irq ==
            (st.ctrl[CTL_IRQ_EN] && st.stat[ST_TX_EMPTY] && st.stat[ST_TX_IRQ_EN]);
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("empty flag interrupt gating wrong");

    property p_dropout;
        @(posedge clk) disable iff (sys_rst)
            st.state == SSP_SHIFT && port_on && !master && !selected && st.cnt != 4'h0 |=> st.stat[ST_DROPOUT];
    endproperty
    a_dropout: assert property (p_dropout) else $error("select dropout not flagged");

    property p_off_pins;
        @(posedge clk) disable iff (sys_rst) !port_on |=> p1_oe == 8'h00;
    endproperty
    a_off_pins: assert property (p_off_pins) else $error("pins driven while port off");

endmodule
`default_nettype wire

// File: ssp_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset; DEPTH is a power of two.
`timescale 1ns/10ps
`default_nettype none
module ssp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } ssp_fifo_s;

    ssp_fifo_s st;
    ssp_fifo_s next_st;
    logic full;
    logic empty;

    assign full = (st.wr[AW] != st.rd[AW]) && (st.wr[AW-1:0] == st.rd[AW-1:0]);
    assign empty = st.wr == st.rd;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = st.mem[st.rd[AW-1:0]];

    // ********************************************************************
    // Pointer and storage update
    // ********************************************************************
    always_comb begin
        next_st = st;
        if (in_valid && !full) begin
            next_st.mem[st.wr[AW-1:0]] = in_data;
            next_st.wr = st.wr + 1'b1;
        end
        if (out_ready && !empty) begin
            next_st.rd = st.rd + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule
`default_nettype wire

// File: ssp_pkg.sv
// Constants for the serial peripheral port: register indices, field positions,
// reset values, pin positions on port one, shifter states and buffer sizes.
// Assumes the importing modules run on one 100 MHz clock with synchronous reset.
package ssp_pkg;

    // ********************************************************************
    // Bus and register map
    // ********************************************************************
    localparam int BUS_AW = 10;
    localparam int BUS_DW = 32;
    localparam logic [7:0] IDX_CTRL = 8'hC3;
    localparam logic [7:0] IDX_STAT = 8'hC4;
    localparam logic [7:0] IDX_DATA = 8'hC5;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_STAT = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;

    // ********************************************************************
    // Control register fields
    // ********************************************************************
    localparam int CTL_RATE_LO = 0;
    localparam int CTL_MASTER = 3;
    localparam int CTL_SEL_IGNORE = 4;
    localparam int CTL_PORT_ON = 5;
    localparam int CTL_IRQ_EN = 6;
    localparam int CTL_ENHANCED = 7;
    localparam logic [2:0] RATE_TIMER = 3'h7;

    // ********************************************************************
    // Status register fields
    // ********************************************************************
    localparam int ST_XFER_DONE = 7;
    localparam int ST_WRITE_CLASH = 6;
    localparam int ST_DROPOUT = 5;
    localparam int ST_MASTER_CLASH = 4;
    localparam int ST_TX_EMPTY = 3;
    localparam int ST_BIT_ORDER = 2;
    localparam int ST_REMAP = 1;
    localparam int ST_TX_IRQ_EN = 0;

    // ********************************************************************
    // Pin positions on port one, default and remapped
    // ********************************************************************
    localparam logic [2:0] PIN_SS_DEF = 3'h4;
    localparam logic [2:0] PIN_MOSI_DEF = 3'h5;
    localparam logic [2:0] PIN_MISO_DEF = 3'h6;
    localparam logic [2:0] PIN_SCK_DEF = 3'h7;
    localparam logic [2:0] PIN_SS_ALT = 3'h0;
    localparam logic [2:0] PIN_MOSI_ALT = 3'h1;
    localparam logic [2:0] PIN_MISO_ALT = 3'h2;
    localparam logic [2:0] PIN_SCK_ALT = 3'h3;

    // ********************************************************************
    // Shifter and buffer
    // ********************************************************************
    localparam logic [3:0] BITS_LAST = 4'h7;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 32;

    typedef enum logic [1:0] {
        SSP_IDLE = 2'b00,
        SSP_SHIFT = 2'b01,
        SSP_DONE = 2'b11
    } ssp_state_e;

endpackage

// File: ssp_spi_peer.sv
// SPI slave model for the bench: mode 0, MSB first, always selected while active.
// Assumes sck and mosi are the port-one outputs of the port, synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module ssp_spi_peer (
    // Clock and pins
    input wire logic clk,
    input wire logic remap,
    input wire logic active,
    input wire logic [7:0] pins,
    // Data
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte,
    output logic [7:0] per
);
    logic [7:0] rxs = 8'h00;
    logic [7:0] cyc = 8'h00;
    logic [2:0] cnt = 3'h0;
    logic sck_q = 1'b0;
    logic last = 1'b0;
    wire logic sck = remap ? pins[3] : pins[7];
    wire logic mosi = remap ? pins[1] : pins[5];
    wire logic [2:0] idx = cnt + {2'b00, sck & ~sck_q};
    // A released line shows the inverse of its last level.
    assign miso = active ? tx_byte[3'h7 - idx] : ~last;
    always @(posedge clk) begin
        sck_q <= sck;
        cyc <= cyc + 8'h01;
        if (active) last <= miso;
        if (sck && !sck_q) begin
            rxs <= {rxs[6:0], mosi};
            per <= cyc;
            cyc <= 8'h01;
            cnt <= cnt + 3'h1;
            if (cnt == 3'h7) rx_byte <= {rxs[6:0], mosi};
        end
    end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench of the serial port: register bus, master transfers, flags.
// Assumes the peer model answers as a mode 0 slave on the port-one pins.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    import ssp_pkg::*;
    // ************************************************************
    // Signals, tasks and checks
    // ************************************************************
    logic clk = 1'b0, sys_rst = 1'b1, rd = 1'b0, wr = 1'b0, chk = 1'b0, ovf = 1'b0;
    logic rmp = 1'b0, pact = 1'b0, ss_n = 1'b1, miso, irq, wq, ssck = 1'b0, smosi = 1'b0;
    logic [9:0] adr = '0;
    logic [31:0] wdat = '0, rdat, seed = 32'h4c30;
    logic [7:0] p1_in, p1_out, p1_oe, ext, ptx = 8'h00, prx, per, r, d, dk, echo;
    logic [7:0] eq[$], mq[$];
    int errors = 0, tests_run = 0, tc = 0;
    always #5 clk = ~clk;
    always @(posedge clk) begin
        tc <= tc + 1;
        ovf <= (tc % 5 == 0);
    end
    always_comb begin
        ext = 8'hFF;
        ext[rmp ? PIN_SS_ALT : PIN_SS_DEF] = ss_n;
        ext[rmp ? PIN_MISO_ALT : PIN_MISO_DEF] = miso;
        ext[rmp ? PIN_SCK_ALT : PIN_SCK_DEF] = ssck;
        ext[rmp ? PIN_MOSI_ALT : PIN_MOSI_DEF] = smosi;
    end
    assign p1_in = (p1_oe & p1_out) | (~p1_oe & ext);
    ssp_core i_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wq), .timer1_ovf(ovf),
        .port_irq(irq), .p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe));
    ssp_spi_peer i_peer (.clk(clk), .remap(rmp), .active(pact), .pins(p1_out), .tx_byte(ptx),
        .miso(miso), .rx_byte(prx), .per(per));
    always @(posedge clk) if (rd && chk && !wq) begin
        `CHK(rdat & {24'h0, mq[0]}, {24'h0, eq[0] & mq[0]})
        void'(eq.pop_front());
        void'(mq.pop_front());
    end
    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev[i] = v[7-i];
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic stop_test;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] v, input logic c);
        int n;
        @(posedge clk);
        adr <= {idx, 2'b00};
        wdat <= {24'h0, v};
        rd <= !w;
        wr <= w;
        chk <= c;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wq !== 1'b0 && n < 50);
        if (n == 50) errors++;
        r = rdat[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        chk <= 1'b0;
    endtask
    task automatic rdq(input logic [7:0] idx, input logic [7:0] e, input logic [7:0] m);
        eq.push_back(e);
        mq.push_back(m);
        acc(1'b0, idx, 8'h00, 1'b1);
    endtask
    task automatic wait_stat(input logic [7:0] m);
        int k;
        for (k = 0; k < 400; k++) begin
            acc(1'b0, IDX_STAT, 8'h00, 1'b0);
            if ((r & m) === m) break;
        end
        `CHK(r & m, m)
    endtask
    initial begin
        #500000;
        errors++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rdq(IDX_STAT, RST_STAT, 8'hFF);
        rdq(IDX_DATA, RST_DATA, 8'hFF);
        rdq(IDX_CTRL, RST_CTRL, 8'hFF);
        acc(1'b1, 8'h10, 8'h5A, 1'b0);
        rdq(8'h10, 8'h00, 8'hFF);
        for (int c = 0; c < 8; c++) begin
            rmp <= c[1];
            acc(1'b1, IDX_STAT, {5'h0, c[0], c[1], 1'b0}, 1'b0);
            // configure first, then enable; master before peer.
            acc(1'b1, IDX_CTRL, 8'h18 | c, 1'b0);
            acc(1'b1, IDX_CTRL, 8'h38 | c, 1'b0);
            pact <= 1'b1;
            seed = xs(seed);
            ptx <= seed[7:0];
            seed = xs(seed);
            d = seed[7:0];
            acc(1'b1, IDX_DATA, d, 1'b0);
            wait_stat(8'h80);
            rdq(IDX_STAT, 8'h88, 8'hC8);
            rdq(IDX_DATA, c[0] ? rev(ptx) : ptx, 8'hFF);
            rdq(IDX_STAT, 8'h00, 8'h80);
            `CHK(prx, c[0] ? rev(d) : d)
            `CHK(per, c == 7 ? 8'h0A : 8'h02 << c)
            `CHK(p1_oe, rmp ? 8'h0A : 8'hA0)
        end
        acc(1'b1, IDX_CTRL, 8'h18, 1'b0);
        for (int i = 0; i < 33; i++) begin
            seed = xs(seed);
            d = seed[7:0];
            acc(1'b1, IDX_DATA, d, 1'b0);
            if (i == 31) begin
                dk = d;
                rdq(IDX_STAT, 8'h00, 8'h40);
            end
        end
        acc(1'b0, IDX_DATA, 8'h00, 1'b0);
        rdq(IDX_STAT, 8'h40, 8'h40);
        acc(1'b0, IDX_DATA, 8'h00, 1'b0);
        rdq(IDX_STAT, 8'h00, 8'h40);
        acc(1'b1, IDX_CTRL, 8'h38, 1'b0);
        for (int i = 0; i < 32; i++) begin
            wait_stat(8'h80);
            acc(1'b0, IDX_DATA, 8'h00, 1'b0);
        end
        `CHK(prx, rev(dk))
        rmp <= 1'b0;
        acc(1'b1, IDX_STAT, {5'h01, 2'b10, 1'b0}, 1'b0);
        acc(1'b1, IDX_CTRL, 8'h68, 1'b0);
        ss_n <= 1'b0;
        repeat (3) @(posedge clk);
        ss_n <= 1'b1;
        rdq(IDX_STAT, 8'h18, 8'h18);
        `CHK(irq, 1'b1)
        acc(1'b0, IDX_DATA, 8'h00, 1'b0);
        rdq(IDX_STAT, 8'h10, 8'h10);
        acc(1'b1, IDX_STAT, 8'h0C, 1'b0);
        @(negedge clk);
        `CHK(irq, 1'b0)
        acc(1'b1, IDX_STAT, 8'h0D, 1'b0);
        @(negedge clk);
        `CHK(irq, 1'b1)
        acc(1'b1, IDX_CTRL, 8'h08, 1'b0);
        repeat (2) @(negedge clk);
        `CHK(p1_oe, 8'h00)
        `CHK(irq, 1'b0)
        // slave echo, then select lost mid-byte.
        acc(1'b1, IDX_CTRL, 8'h00, 1'b0);
        acc(1'b1, IDX_CTRL, 8'h20, 1'b0);
        seed = xs(seed);
        d = seed[7:0];
        ss_n <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            if (i == 8) repeat (4) @(posedge clk);
            smosi <= d[i % 8];
            repeat (2) @(posedge clk);
            ssck <= 1'b1;
            repeat (2) @(posedge clk);
            if (i < 8) echo[i] = p1_out[PIN_MISO_DEF];
            ssck <= 1'b0;
        end
        ss_n <= 1'b1;
        `CHK(echo, rev(ptx))
        rdq(IDX_DATA, d, 8'hFF);
        rdq(IDX_STAT, 8'h20, 8'h20);
        stop_test();
    end
endmodule
`default_nettype wire
